// ### srp_serial_port.sv
// Device side of the four-wire serial register port
// Assumes sclk, select_n and serial_in are asynchronous pins
// Assumes sys_clk runs at least eight times the serial clock
//
// Overview of operation
// - Serial traffic counts only while select is held low.
// - Each input bit is taken on a rising serial clock edge.
// - Any serial clock rate works, down to a stopped clock.
// - A single access is one 24-bit frame: flag, address, data.
// - All fields go most significant bit first, in and out.
// - Multi-byte registers keep their low byte at the lowest address.
// - Serial output floats except while read data is returned.
// - First frame bit: one means read, zero means write.
// - The next 15 bits carry the register address.
// - Write frames store the final eight input bits.
// - Read frames ignore final input bits and drive register data out.
// - Streaming moves one more byte per eight clocks while selected.
// - Streaming steps the address by one per byte, up or down.
// - Address direction bit 5 of register zero: set ascends; bit 2 is unused.
// - Stream-hold control keeps the address fixed during streaming.
// - Standard configuration block decodes at 0x000 to 0x00F.
// - User configuration block at 0x010 to 0x01F, one register.
`timescale 1ns/1ps

module srp_serial_port (
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  input  wire logic  sclk,
  input  wire logic  select_n,
  input  wire logic  serial_in,
  output logic       serial_out,
  output logic       serialOutOe_n,
  output logic [7:0] devOperatingConfig
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  srp_pkg::srp_pins_t pinsRaw;
  srp_pkg::srp_pins_t pinsS;

  assign pinsRaw = '{sclk: sclk, selectN: select_n, serialIn: serial_in};

  srp_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinsIn  (pinsRaw),
    .pinsOut (pinsS)
  );

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic sclkPrev_q;

  // No timeout anywhere: a paused clock just waits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_q <= 1'b0;
    end else begin
      sclkPrev_q <= pinsS.sclk;
    end
  end

  wire selActive = !pinsS.selectN;
  wire rise      = selActive && pinsS.sclk && !sclkPrev_q;
  wire sin       = pinsS.serialIn;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  srp_pkg::srp_state_t state_q;
  srp_pkg::srp_state_t stateD;
  logic [3:0]          bitIdx_q;
  logic [3:0]          bitIdxD;
  logic                rw_q;
  logic [14:0]         addr_q;
  logic [14:0]         addrD;
  logic [7:0]          shiftIn_q;
  logic [7:0]          rdShift_q;
  logic                loadRd_q;
  logic                serialOut_q;
  logic                oeN_q;

  wire inIdle = (state_q == srp_pkg::SRP_IDLE);
  wire inAddr = (state_q == srp_pkg::SRP_ADDR);
  wire inData = (state_q == srp_pkg::SRP_DATA);

  wire addrEnd = rise && inAddr && (bitIdx_q == srp_pkg::ADDR_LAST);
  wire byteEnd = rise && inData && (bitIdx_q == srp_pkg::BYTE_LAST);
  wire restart = !selActive || (rise && (inIdle || addrEnd || byteEnd));

  // ----------------------------------------
  // Configuration controls
  // ----------------------------------------
  logic [7:0] cfgPrimary;
  logic [7:0] usrCfg;
  logic [7:0] rdData;

  wire ascending = cfgPrimary[srp_pkg::DIR_BIT_HI];
  wire holdAddr  = usrCfg[srp_pkg::HOLD_BIT];

  // Bit 2 is stored as written and not used; only bit 5 steers
  function automatic logic [14:0] stepAddr(input logic [14:0] a,
                                           input logic        up,
                                           input logic        hold);
    logic [14:0] n;
    n = a;
    if (hold) begin
      n = a;
    end else if (up) begin
      n = a + 15'h0001;
    end else begin
      n = a - 15'h0001;
    end
    return n;
  endfunction

  // ----------------------------------------
  // Next-state selection
  // ----------------------------------------
  assign stateD = !selActive ? srp_pkg::SRP_IDLE :
                  !rise      ? state_q :
                  inIdle     ? srp_pkg::SRP_ADDR :
                  addrEnd    ? srp_pkg::SRP_DATA :
                               state_q;

  assign bitIdxD = restart ? 4'h0 :
                   rise    ? 4'(bitIdx_q + 4'h1) :
                             bitIdx_q;

  // Address shifts in MSB first, then steps per byte
  assign addrD = (rise && inAddr) ? {addr_q[13:0], sin} :
                 byteEnd          ? stepAddr(addr_q, ascending, holdAddr) :
                                    addr_q;

  wire loadRdD = (addrEnd || byteEnd) && rw_q && selActive;
  wire rdShift = rise && inData && rw_q && (bitIdx_q != srp_pkg::BYTE_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= srp_pkg::SRP_IDLE;
      bitIdx_q <= 4'h0;
      addr_q   <= 15'h0000;
      loadRd_q <= 1'b0;
    end else begin
      state_q  <= stateD;
      bitIdx_q <= bitIdxD;
      addr_q   <= addrD;
      loadRd_q <= loadRdD;
    end
  end

  // Flag is the very first bit of the frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_q <= 1'b0;
    end else if (rise && inIdle) begin
      rw_q <= sin;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn_q <= 8'h00;
    end else if (rise && inData) begin
      shiftIn_q <= {shiftIn_q[6:0], sin};
    end
  end

  // ----------------------------------------
  // Write commit
  // ----------------------------------------
  srp_pkg::srp_wr_t wrReq;

  // Only a full byte commits; a cut-off partial byte writes nothing
  assign wrReq.en   = byteEnd && !rw_q;
  assign wrReq.addr = addr_q;
  assign wrReq.data = {shiftIn_q[6:0], sin};

  srp_regs u_regs (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .wrReq      (wrReq),
    .rdAddr     (addr_q),
    .rdData     (rdData),
    .cfgPrimary (cfgPrimary),
    .devCfg     (devOperatingConfig),
    .usrCfg     (usrCfg)
  );

  // ----------------------------------------
  // Read data output
  // ----------------------------------------
  // Output moves just after a rising edge, so the host
  // sees each bit stable for a whole serial period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdShift_q   <= 8'h00;
      serialOut_q <= 1'b0;
      oeN_q       <= 1'b1;
    end else if (!selActive) begin
      serialOut_q <= 1'b0;
      oeN_q       <= 1'b1;
    end else if (loadRd_q) begin
      rdShift_q   <= rdData;
      serialOut_q <= rdData[7];
      oeN_q       <= 1'b0;
    end else if (rdShift) begin
      rdShift_q   <= {rdShift_q[6:0], 1'b0};
      serialOut_q <= rdShift_q[6];
    end
  end

  assign serial_out    = serialOut_q;
  assign serialOutOe_n = oeN_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!rst_n);

  sequence s_rd_addr_done;
    addrEnd && rw_q;
  endsequence

  sequence s_rd_loaded;
    s_rd_addr_done ##1 selActive ##1 selActive;
  endsequence

  sequence s_byte_step;
    byteEnd && !holdAddr;
  endsequence

  sequence s_rd_next;
    byteEnd && rw_q ##1 selActive ##1 selActive;
  endsequence

  a_deselect_idle: assert property (
    !selActive |=> (state_q == srp_pkg::SRP_IDLE) && serialOutOe_n)
    else $error("Frame not ended on deselect");

  a_edge_only: assert property (
    $changed(bitIdx_q) |-> $past(rise || !selActive))
    else $error("Bit count moved without a rising edge");

  a_rw_capture: assert property (
    rise && inIdle |=> rw_q == $past(sin))
    else $error("Read flag not taken from first bit");

  a_addr_lsb: assert property (
    addrEnd |=> addr_q[0] == $past(sin) && inData)
    else $error("Last address bit not captured");

  a_oe_read_only: assert property (
    !serialOutOe_n |-> rw_q && inData)
    else $error("Output driven outside read data");

  a_read_drive: assert property (
    s_rd_loaded |-> !serialOutOe_n && serial_out == $past(rdData[7]))
    else $error("Read data MSB not driven");

  a_write_store: assert property (
    byteEnd && !rw_q && addr_q == srp_pkg::OFS_DEV_CFG
    |=> devOperatingConfig == $past(wrReq.data))
    else $error("Write byte not stored");

  a_stream_wrap: assert property (
    byteEnd |=> inData && bitIdx_q == 4'h0)
    else $error("Stream did not continue with next byte");

  a_addr_ascend: assert property (
    (s_byte_step and ascending) |=> addr_q == 15'($past(addr_q) + 15'h0001))
    else $error("Address did not increment");

  a_addr_descend: assert property (
    (s_byte_step and !ascending) |=> addr_q == 15'($past(addr_q) - 15'h0001))
    else $error("Address did not decrement");

  a_addr_hold: assert property (
    byteEnd && holdAddr |=> $stable(addr_q))
    else $error("Address moved while held");

  a_frame_start: assert property (
    rise && inIdle |=> inAddr && bitIdx_q == 4'h0)
    else $error("Frame did not start address phase");

  a_cut_frame: assert property (
    inData && !selActive |-> !wrReq.en ##1 (inIdle && bitIdx_q == 4'h0))
    else $error("Cut frame not dropped");

  a_out_stands: assert property (
    selActive && !rise && !loadRd_q |=> $stable(serial_out))
    else $error("Read bit changed between clock edges");

  a_stream_reload: assert property (
    s_rd_next |-> !serialOutOe_n && serial_out == $past(rdData[7]))
    else $error("Next streamed byte not driven");

  a_oe_write: assert property (
    inData && !rw_q |-> serialOutOe_n)
    else $error("Output driven during write data");

  a_usr_write: assert property (
    byteEnd && !rw_q && addr_q == srp_pkg::OFS_USR_CFG |=> usrCfg == $past(wrReq.data))
    else $error("User configuration write not stored");

  a_ro_ignore: assert property (
    byteEnd && !rw_q && addr_q == srp_pkg::OFS_PART_LO
    |=> $stable(cfgPrimary) && $stable(usrCfg) && $stable(devOperatingConfig))
    else $error("Write to read-only address changed a register");

  a_read_no_store: assert property (
    byteEnd && rw_q
    |=> $stable(cfgPrimary) && $stable(usrCfg) && $stable(devOperatingConfig))
    else $error("Read frame input bits were stored");

endmodule

// ### srp_pkg.sv
// Shared constants and types of the serial register port
// Assumes every user names items as srp_pkg::name
package srp_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [14:0] OFS_CFG_PRI  = 15'h0000;
  localparam logic [14:0] OFS_DEV_CFG  = 15'h0002;
  localparam logic [14:0] OFS_CLASS    = 15'h0003;
  localparam logic [14:0] OFS_PART_LO  = 15'h0004;
  localparam logic [14:0] OFS_PART_HI  = 15'h0005;
  localparam logic [14:0] OFS_REV      = 15'h0006;
  localparam logic [14:0] OFS_MAKER_LO = 15'h000c;
  localparam logic [14:0] OFS_MAKER_HI = 15'h000d;
  localparam logic [14:0] OFS_USR_CFG  = 15'h0010;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] RST_CFG_PRI = 8'h30;
  localparam logic [7:0] RST_DEV_CFG = 8'h00;
  localparam logic [7:0] RST_USR_CFG = 8'h00;
  localparam logic [7:0] RSVD_READ   = 8'h00;
  localparam int         DIR_BIT_HI  = 5;
  localparam int         DIR_BIT_LO  = 2;
  localparam int         HOLD_BIT    = 0;

  // ----------------------------------------
  // Frame bit counts
  // ----------------------------------------
  localparam logic [3:0] ADDR_LAST = 4'he;
  localparam logic [3:0] BYTE_LAST = 4'h7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRP_IDLE = 2'b00,
    SRP_ADDR = 2'b01,
    SRP_DATA = 2'b11
  } srp_state_t;

  typedef struct packed {
    logic        en;
    logic [14:0] addr;
    logic [7:0]  data;
  } srp_wr_t;

  typedef struct packed {
    logic sclk;
    logic selectN;
    logic serialIn;
  } srp_pins_t;

  localparam srp_pins_t PINS_RST = '{sclk: 1'b0, selectN: 1'b1, serialIn: 1'b0};

endpackage

// ### srp_sync.sv
// Two-stage synchroniser for the serial pins
// Assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps

module srp_sync (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire srp_pkg::srp_pins_t pinsIn,
  output srp_pkg::srp_pins_t     pinsOut
);

  srp_pkg::srp_pins_t meta_q;
  srp_pkg::srp_pins_t sync_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= srp_pkg::PINS_RST;
      sync_q <= srp_pkg::PINS_RST;
    end else begin
      meta_q <= pinsIn;
      sync_q <= meta_q;
    end
  end

  assign pinsOut = sync_q;

endmodule

// ### srp_regs.sv
// Register file of the serial register port
// Assumes one write request per cycle from the frame engine
`timescale 1ns/1ps

module srp_regs #(
  parameter logic [7:0]  PART_CLASS = 8'h5a,     // Arbitrary value
  parameter logic [15:0] PART_NUM   = 16'h1234,  // Arbitrary value
  parameter logic [7:0]  SILICON_REV = 8'h01,    // Arbitrary value
  parameter logic [15:0] MAKER      = 16'h7e7e   // Arbitrary value
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire srp_pkg::srp_wr_t wrReq,
  input  wire logic [14:0]      rdAddr,
  output logic [7:0]            rdData,
  output logic [7:0]            cfgPrimary,
  output logic [7:0]            devCfg,
  output logic [7:0]            usrCfg
);

  logic [7:0] cfgPri_q;
  logic [7:0] devCfg_q;
  logic [7:0] usrCfg_q;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [7:0] readMux(input logic [14:0] a,
                                         input logic [7:0] c0,
                                         input logic [7:0] c2,
                                         input logic [7:0] cu);
    logic [7:0] v;
    v = srp_pkg::RSVD_READ;
    case (a)
      srp_pkg::OFS_CFG_PRI:  v = c0;
      srp_pkg::OFS_DEV_CFG:  v = c2;
      srp_pkg::OFS_CLASS:    v = PART_CLASS;
      srp_pkg::OFS_PART_LO:  v = PART_NUM[7:0];
      srp_pkg::OFS_PART_HI:  v = PART_NUM[15:8];
      srp_pkg::OFS_REV:      v = SILICON_REV;
      srp_pkg::OFS_MAKER_LO: v = MAKER[7:0];
      srp_pkg::OFS_MAKER_HI: v = MAKER[15:8];
      srp_pkg::OFS_USR_CFG:  v = cu;
      default:               v = srp_pkg::RSVD_READ;
    endcase
    return v;
  endfunction

  assign rdData = readMux(rdAddr, cfgPri_q, devCfg_q, usrCfg_q);

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  wire wrPri = wrReq.en && (wrReq.addr == srp_pkg::OFS_CFG_PRI);
  wire wrDev = wrReq.en && (wrReq.addr == srp_pkg::OFS_DEV_CFG);
  wire wrUsr = wrReq.en && (wrReq.addr == srp_pkg::OFS_USR_CFG);

  // Read-only and reserved addresses drop writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgPri_q <= srp_pkg::RST_CFG_PRI;
      devCfg_q <= srp_pkg::RST_DEV_CFG;
      usrCfg_q <= srp_pkg::RST_USR_CFG;
    end else begin
      if (wrPri) cfgPri_q <= wrReq.data;
      if (wrDev) devCfg_q <= wrReq.data;
      if (wrUsr) usrCfg_q <= wrReq.data;
    end
  end

  assign cfgPrimary = cfgPri_q;
  assign devCfg     = devCfg_q;
  assign usrCfg     = usrCfg_q;

endmodule

// ### srp_host_model.sv
// Host controller model for the serial register port
// Assumes the bench resolves the data-out pin from the output enable
`timescale 1ns/1ps

module srp_host_model (
  output logic      sclk,
  output logic      select_n,
  output logic      serial_in,
  input  wire logic serialPin
);
  int   halfNs = 100;
  logic isRead = 1'b0;
  int   phase  = 0;

  // Link clock stands still low between frames
  initial begin
    sclk      = 1'b0;
    select_n  = 1'b1;
    serial_in = 1'b0;
  end

  // ----------------------------------------
  // One link clock
  // ----------------------------------------
  task automatic bit_cycle(input logic b, output logic s);
    serial_in = b;
    #(halfNs);
    sclk = 1'b1;
    s    = serialPin;
    #(halfNs);
    sclk = 1'b0;
  endtask

  // ----------------------------------------
  // Frame: flag, 15 address bits, nData data bits
  // ----------------------------------------
  // No calibration exists here, so any moment is a legal access time
  task automatic frame(input logic        rd,
                       input logic [14:0] addr,
                       input int          nData,
                       input logic [31:0] wd,
                       output logic [31:0] rdata);
    logic        s;
    logic [15:0] hdr;
    hdr      = {rd, addr};
    isRead   = rd;
    rdata    = '0;
    phase    = 1;
    select_n = 1'b0;
    #(halfNs);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(hdr[i], s);
    end
    phase = 2;
    for (int i = 0; i < nData; i++) begin
      bit_cycle(wd[31 - i], s);
      rdata = {rdata[30:0], s};
    end
    select_n  = 1'b1;
    // Released line must not keep its last value
    serial_in = ~serial_in;
    #(2 * halfNs);
    phase = 0;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench of the serial register port
// Assumes the design's default identity parameters
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0]  CLS = 8'h5a;   // Arbitrary value
  localparam logic [15:0] PRT = 16'h1234; // Arbitrary value
  localparam logic [7:0]  REV = 8'h01;   // Arbitrary value
  localparam logic [15:0] MKR = 16'h7e7e; // Arbitrary value

  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        sclk;
  logic        select_n;
  logic        serial_in;
  logic        serial_out;
  logic        serialOutOe_n;
  logic [7:0]  devOperatingConfig;
  wire         serialPin;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] rd;

  assign serialPin = serialOutOe_n ? 1'bz : serial_out;

  always #12.5 sys_clk = ~sys_clk;

  srp_serial_port u_dut (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .sclk               (sclk),
    .select_n           (select_n),
    .serial_in          (serial_in),
    .serial_out         (serial_out),
    .serialOutOe_n      (serialOutOe_n),
    .devOperatingConfig (devOperatingConfig)
  );

  srp_host_model u_host (
    .sclk      (sclk),
    .select_n  (select_n),
    .serial_in (serial_in),
    .serialPin (serialPin)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cfg(input logic [7:0] e);
    check({24'h0, devOperatingConfig}, {24'h0, e}, "config output");
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_host.frame(1'b0, a, 8, {d, 24'h0}, rd);
  endtask

  // Input held high while reading, which the device must ignore
  task automatic rdchk(input logic [14:0] a, input int n, input logic [31:0] exp);
    u_host.frame(1'b1, a, n, 32'hffffffff, rd);
    check(rd, exp, "read data");
  endtask

  // Output floats outside read data
  always @(posedge sys_clk) begin
    if (rst_n && !(u_host.phase == 2 && u_host.isRead) && serialOutOe_n !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: output driven outside read data", $time);
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    cfg(8'h00);
    rdchk(15'h0000, 8, 32'h30);
    rdchk(15'h0010, 8, 32'h00);
  endtask

  task automatic t_write;
    wr(15'h0002, 8'ha5);
    cfg(8'ha5);
    rdchk(15'h0002, 8, 32'ha5);
    cfg(8'ha5);
  endtask

  task automatic t_ids;
    rdchk(15'h0003, 32, {CLS, PRT[7:0], PRT[15:8], REV});
    rdchk(15'h000c, 16, {16'h0, MKR[7:0], MKR[15:8]});
  endtask

  task automatic t_refuse;
    wr(15'h0004, 8'hff);
    wr(15'h0001, 8'h55);
    rdchk(15'h0004, 8, {24'h0, PRT[7:0]});
    rdchk(15'h0001, 8, 32'h00);
    rdchk(15'h0011, 8, 32'h00);
  endtask

  task automatic t_down;
    wr(15'h0000, 8'h00);
    rdchk(15'h0006, 24, {8'h0, REV, PRT[15:8], PRT[7:0]});
    rdchk(15'h0000, 8, 32'h00);
    wr(15'h0000, 8'h30);
  endtask

  task automatic t_stream_wr;
    u_host.frame(1'b0, 15'h0001, 16, {8'h55, 8'h3c, 16'h0}, rd);
    cfg(8'h3c);
  endtask

  task automatic t_hold;
    wr(15'h0010, 8'h01);
    rdchk(15'h0010, 8, 32'h01);
    u_host.frame(1'b0, 15'h0002, 16, {8'h11, 8'h22, 16'h0}, rd);
    cfg(8'h22);
    rdchk(15'h0003, 16, {16'h0, CLS, CLS});
    wr(15'h0010, 8'h00);
  endtask

  task automatic t_cut;
    u_host.frame(1'b0, 15'h0002, 5, 32'h0, rd);
    cfg(8'h22);
    u_host.frame(1'b0, 15'h0002, 12, {8'h44, 24'h0}, rd);
    cfg(8'h44);
  endtask

  // Very slow link clock, period thirty times the bench default
  task automatic t_slow;
    u_host.halfNs = 3000;
    wr(15'h0002, 8'h96);
    u_host.halfNs = 100;
    cfg(8'h96);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // Host pins then move 2 ns after a clock edge, never on it
    #2;
    t_reset();
    t_write();
    t_ids();
    t_refuse();
    t_down();
    t_stream_wr();
    t_hold();
    t_cut();
    t_slow();
    print_verdict();
  end

  // Whole run needs about 0.3 ms of simulated time
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule
